// file: rtl/adc_ddr_pkg.sv
// Shared constants for the converter output formatter and config port
package adc_ddr_pkg;
   localparam int SAMPLE_BITS    = 12;
   localparam int PAIR_COUNT     = 6;
   localparam int LATENCY_CYCLES = 6;
   localparam int REG_BITS       = 8;
   localparam int ADDR_BITS      = 7;
   localparam int FRAME_BITS     = 16;
   localparam int REG_COUNT      = 5;
   // Register index values inside the serial frame
   localparam logic [6:0] ADDR_RESET  = 7'h00;
   localparam logic [6:0] ADDR_POWER  = 7'h01;
   localparam logic [6:0] ADDR_TIMING = 7'h02;
   localparam logic [6:0] ADDR_OUTPUT = 7'h03;
   localparam logic [6:0] ADDR_FORMAT = 7'h04;
   // Field positions
   localparam int TIM_DCS_POS     = 0;
   localparam int TIM_PHASE_POS   = 1;
   localparam int TIM_INV_POS     = 3;
   localparam int PWR_SLEEP_POS   = 0;
   localparam int OUT_LOWCUR_POS  = 0;
   // Values after reset
   localparam logic [7:0] RST_POWER  = 8'h00;
   localparam logic [7:0] RST_TIMING = 8'h00;
   localparam logic [7:0] RST_OUTPUT = 8'h00;
   localparam logic [7:0] RST_FORMAT = 8'h00;
   localparam logic [2:0] RST_PHASE_CNT = 3'h0;
endpackage : adc_ddr_pkg

// file: rtl/adc_spi_regs.sv
// Serial configuration port with register storage and readback
`timescale 1ns/1ps
`default_nettype none
module adc_spi_regs
   import adc_ddr_pkg::*;
(
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                clkEn,
   // Synchronised serial pins
   input  wire logic                serialMode,
   input  wire logic                csSync,
   input  wire logic                sckSync,
   input  wire logic                sdiSync,
   // Readback drive, open drain
   output logic                     sdoOut,
   output logic                     sdoOe,
   // Register contents
   output logic [REG_BITS-1:0]      powerReg,
   output logic [REG_BITS-1:0]      timingReg,
   output logic [REG_BITS-1:0]      outputReg,
   output logic [REG_BITS-1:0]      formatReg
);
   typedef struct packed {
      logic                  sckPrev;
      logic [4:0]            bitCnt;
      logic [FRAME_BITS-1:0] shift;
      logic                  readOp;
      logic [REG_BITS-1:0]   rdData;
      logic                  sdoLow;
      logic [REG_BITS-1:0]   power;
      logic [REG_BITS-1:0]   timing;
      logic [REG_BITS-1:0]   outp;
      logic [REG_BITS-1:0]   format;
   } spi_t;
   spi_t s_q, s_d;

   function automatic logic [REG_BITS-1:0] readReg(input logic [6:0] a,
                                                   input spi_t st);
      case (a)
         ADDR_POWER:  readReg = st.power;
         ADDR_TIMING: readReg = st.timing;
         ADDR_OUTPUT: readReg = st.outp;
         ADDR_FORMAT: readReg = st.format;
         default:     readReg = 8'h00;
      endcase
   endfunction : readReg

   always_comb begin
      logic rise;
      logic fall;
      logic [FRAME_BITS-1:0] nxt;
      s_d  = s_q;
      rise = sckSync & ~s_q.sckPrev;
      fall = ~sckSync & s_q.sckPrev;
      nxt  = {s_q.shift[FRAME_BITS-2:0], sdiSync};
      s_d.sckPrev = sckSync;
      if (!serialMode || csSync) begin
         // Frame ends or never began
         s_d.bitCnt = 5'h00;
         s_d.sdoLow = 1'b0;
      end else begin
         if (rise) begin
            s_d.shift  = nxt;
            s_d.bitCnt = s_q.bitCnt + 5'h01;
            if (s_q.bitCnt == 5'd0) s_d.readOp = sdiSync;
            if (s_q.bitCnt == 5'd7) s_d.rdData = readReg(nxt[6:0], s_q);
            if (s_q.bitCnt == 5'd15 && !s_q.readOp) begin
               case (nxt[14:8])
                  ADDR_RESET: begin
                     // Writing bit 7 of address zero restores defaults
                     if (nxt[7]) begin
                        s_d.power  = RST_POWER;
                        s_d.timing = RST_TIMING;
                        s_d.outp   = RST_OUTPUT;
                        s_d.format = RST_FORMAT;
                     end
                  end
                  ADDR_POWER:  s_d.power  = nxt[7:0];
                  ADDR_TIMING: s_d.timing = nxt[7:0];
                  ADDR_OUTPUT: s_d.outp   = nxt[7:0];
                  ADDR_FORMAT: s_d.format = nxt[7:0];
                  default: ;
               endcase
            end
         end
         if (fall && s_q.readOp && s_q.bitCnt >= 5'd8) begin
            s_d.sdoLow = ~s_q.rdData[REG_BITS-1];
            s_d.rdData = {s_q.rdData[REG_BITS-2:0], 1'b0};
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_q <= '{sckPrev: 1'b0, bitCnt: 5'h00, shift: 16'h0000,
                  readOp: 1'b0, rdData: 8'h00, sdoLow: 1'b0,
                  power: RST_POWER, timing: RST_TIMING,
                  outp: RST_OUTPUT, format: RST_FORMAT};
      end else if (clkEn) begin
         s_q <= s_d;
      end
   end

   assign sdoOut    = 1'b0;
   assign sdoOe     = s_q.sdoLow;
   assign powerReg  = s_q.power;
   assign timingReg = s_q.timing;
   assign outputReg = s_q.outp;
   assign formatReg = s_q.format;
endmodule : adc_spi_regs
`default_nettype wire

// file: rtl/adc_ddr_output.sv
// Converter digital side: DDR output formatter and configuration port
`timescale 1ns/1ps
`default_nettype none
// Operation
// - New conversion on each encode rising edge while not in sleep
// - Two sample bits share each data pair
// - Even bits while clock low, odd high, with the invert bit clear
// - Data changes on both output clock edges
// - Output clock phase delay set by register
// - Flag high when input exceeded full scale
// - Flag forced zero in second half cycle
// - Flag pipelined alongside its data word
// - Strap low selects serial configuration port
// - Strap high makes pins static controls
// - Shift only while chip select low
// - Sample serial input on clock rising edge
// - Readback shifted out on open drain
// - Parallel serial-input pin selects drive current
// - Parallel serial-clock pin controls sleep
// - Parallel chip select enables duty stabilizer
module adc_ddr_output
   import adc_ddr_pkg::*;
#(
   parameter int SAMPLE_W = SAMPLE_BITS,
   parameter int PAIRS    = PAIR_COUNT,
   parameter int LATENCY  = LATENCY_CYCLES
)
(
   // Clock and reset
   input  wire logic                mclk,
   input  wire logic                rst,
   input  wire logic                clkEn,
   // Encode clock and quantiser result
   input  wire logic                encodeClock,
   input  wire logic [SAMPLE_W-1:0] sampleIn,
   input  wire logic                overRangeIn,
   // Configuration pins
   input  wire logic                programmingModeStrap,
   input  wire logic                csN,
   input  wire logic                sck,
   input  wire logic                sdi,
   output logic                     sdoOut,
   output logic                     sdoOe,
   // DDR outputs
   output logic [PAIRS-1:0]         ddrDataPair,
   output logic                     overrangeFlag,
   output logic                     forwardedOutputClock,
   // Mode outputs
   output logic                     sleepMode,
   output logic                     dutyStabilizerOn,
   output logic                     lowDriveCurrent,
   output logic                     twosComplement
);
   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic [4:0] syncA_q;
   logic [4:0] syncB_q;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         syncA_q <= 5'h00;
         syncB_q <= 5'h00;
      end else if (clkEn) begin
         syncA_q <= {encodeClock, programmingModeStrap, csN, sck, sdi};
         syncB_q <= syncA_q;
      end
   end
   logic encS, strapS, csS, sckS, sdiS;
   assign {encS, strapS, csS, sckS, sdiS} = syncB_q;

   ////////////////////////////////////////////////////////////////////////
   // Strap catch: read once after reset, board holds it fixed
   // Waits for the second stage to settle instead of peeking at the first
   logic       strapValid_q;
   logic       parMode_q;
   logic [1:0] strapWait_q;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         strapWait_q  <= 2'h0;
         strapValid_q <= 1'b0;
         parMode_q    <= 1'b0;
      end else if (clkEn && !strapValid_q) begin
         if (strapWait_q == 2'h3) begin
            strapValid_q <= 1'b1;
            parMode_q    <= strapS;
         end else begin
            strapWait_q <= strapWait_q + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial port
   logic [REG_BITS-1:0] powerReg, timingReg, outputReg, formatReg;
   adc_spi_regs u_spi (
      .mclk       (mclk),
      .rst        (rst),
      .clkEn      (clkEn),
      .serialMode (strapValid_q & ~parMode_q),
      .csSync     (csS),
      .sckSync    (sckS),
      .sdiSync    (sdiS),
      .sdoOut     (sdoOut),
      .sdoOe      (sdoOe),
      .powerReg   (powerReg),
      .timingReg  (timingReg),
      .outputReg  (outputReg),
      .formatReg  (formatReg)
   );

   ////////////////////////////////////////////////////////////////////////
   // Formatter state
   typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_HIGH} phase_t;
   typedef struct packed {
      logic                          encPrev;
      logic [LATENCY*SAMPLE_W-1:0]   pipe;
      logic [LATENCY-1:0]            ovPipe;
      logic [SAMPLE_W-1:0]           word;
      logic                          ov;
      phase_t                        phase;
      logic [2:0]                    phaseCnt;
      logic                          clkBase;
      logic [3:0]                    clkHist;
      logic [PAIRS-1:0]              data;
      logic                          flag;
      logic                          fclk;
      logic                          sleep;
      logic                          dcs;
      logic                          lowCur;
   } fmt_t;
   fmt_t f_q, f_d;

   logic [1:0] phaseSel;
   logic       clkInv;
   assign phaseSel = timingReg[TIM_PHASE_POS +: 2];
   assign clkInv   = timingReg[TIM_INV_POS];

   always_comb begin
      logic encRise;
      logic encFall;
      logic baseClk;
      logic delayed;
      f_d     = f_q;
      baseClk = 1'b0;
      delayed = 1'b0;
      encRise = encS & ~f_q.encPrev;
      encFall = ~encS & f_q.encPrev;
      f_d.encPrev = encS;
      if (encRise && !f_q.sleep) begin
         // Shift the latency pipe; data and flag move together
         f_d.pipe   = {f_q.pipe[(LATENCY-1)*SAMPLE_W-1:0], sampleIn};
         f_d.ovPipe = {f_q.ovPipe[LATENCY-2:0], overRangeIn};
         f_d.word   = f_q.pipe[LATENCY*SAMPLE_W-1 -: SAMPLE_W];
         f_d.ov     = f_q.ovPipe[LATENCY-1];
         f_d.phase  = PH_LOW;
      end else if (encFall && f_q.phase != PH_IDLE) begin
         f_d.phase = PH_HIGH;
      end
      case (f_d.phase)
         PH_LOW: begin
            baseClk = 1'b0;
            for (int i = 0; i < PAIRS; i++) begin
               f_d.data[i] = f_d.word[2*i];
            end
            f_d.flag = f_d.ov;
         end
         PH_HIGH: begin
            baseClk = 1'b1;
            for (int i = 0; i < PAIRS; i++) begin
               f_d.data[i] = f_d.word[2*i+1];
            end
            f_d.flag = 1'b0;
         end
         default: begin
            baseClk    = 1'b0;
            f_d.data   = '0;
            f_d.flag   = 1'b0;
         end
      endcase
      // Phase shift in mclk steps; coarse since encode is sampled
      f_d.clkBase = baseClk;
      f_d.clkHist = {f_q.clkHist[2:0], f_q.clkBase};
      f_d.phaseCnt = {1'b0, phaseSel};
      case (phaseSel)
         2'd0:    delayed = baseClk;
         // One mclk of delay per step
         2'd1:    delayed = f_q.clkBase;
         2'd2:    delayed = f_q.clkHist[0];
         default: delayed = f_q.clkHist[1];
      endcase
      f_d.fclk = delayed ^ clkInv;
      // Mode selection by strap
      if (parMode_q) begin
         f_d.lowCur = sdiS;
         f_d.sleep  = sckS;
         f_d.dcs    = csS;
      end else begin
         f_d.lowCur = outputReg[OUT_LOWCUR_POS];
         f_d.sleep  = powerReg[PWR_SLEEP_POS];
         f_d.dcs    = timingReg[TIM_DCS_POS];
      end
      if (!strapValid_q) begin
         f_d.sleep = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         f_q <= '{encPrev: 1'b0, pipe: '0, ovPipe: '0, word: '0, ov: 1'b0,
                  phase: PH_IDLE, phaseCnt: RST_PHASE_CNT, clkBase: 1'b0,
                  clkHist: 4'h0, data: '0, flag: 1'b0, fclk: 1'b0,
                  sleep: 1'b0, dcs: 1'b0, lowCur: 1'b0};
      end else if (clkEn) begin
         f_q <= f_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign ddrDataPair          = f_q.data;
   assign overrangeFlag        = f_q.flag;
   assign forwardedOutputClock = f_q.fclk;
   assign sleepMode            = f_q.sleep;
   assign dutyStabilizerOn     = f_q.dcs;
   assign lowDriveCurrent      = f_q.lowCur;
   assign twosComplement       = ~parMode_q & formatReg[0];
endmodule : adc_ddr_output
`default_nettype wire

// file: verif/adc_ddr_output_sva.sv
// Assertion checker for the converter pins
`timescale 1ns/1ps
`default_nettype none
module adc_ddr_output_sva #(
   parameter int PAIRS = 6
) (
   // Clock and reset
   input wire logic             mclk,
   input wire logic             rst,
   // Watched pins
   input wire logic             encodeClock,
   input wire logic             programmingModeStrap,
   input wire logic             csN,
   input wire logic             sck,
   input wire logic             sdi,
   input wire logic             sdoOut,
   input wire logic             sdoOe,
   input wire logic [PAIRS-1:0] ddrDataPair,
   input wire logic             overrangeFlag,
   input wire logic             forwardedOutputClock,
   input wire logic             sleepMode,
   input wire logic             dutyStabilizerOn,
   input wire logic             lowDriveCurrent
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   ////////////////////
   // Parallel checks wait until the strap has surely been caught
   logic [3:0] upCnt_q, upCnt_d;
   logic       par;
   assign upCnt_d = (upCnt_q == 4'hf) ? upCnt_q : upCnt_q + 4'h1;
   assign par = programmingModeStrap && upCnt_q == 4'hf;
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) upCnt_q <= 4'h0;
      else upCnt_q <= upCnt_d;
   end
   ////////////////////
   sdo_drain_a:
      assert property (sdoOut == 1'b0)
      else $error("sdo data bit not low");
   par_sdo_a:
      assert property (par |-> !sdoOe)
      else $error("sdo active in parallel mode");
   cs_release_a:
      assert property (csN [*6] |-> !sdoOe)
      else $error("sdo active with chip select high");
   par_stab_a:
      assert property ((par && csN) [*8] |-> dutyStabilizerOn)
      else $error("stabilizer not following chip select");
   par_sleep_a:
      assert property ((par && sck) [*8] |-> sleepMode)
      else $error("sleep not following clock pin");
   par_drive_a:
      assert property ((par && !sdi) [*8] |-> !lowDriveCurrent)
      else $error("drive current not following data pin");
   par_flag_a:
      assert property (par && overrangeFlag |-> !forwardedOutputClock)
      else $error("flag high in clock high half");
   par_edge_a:
      assert property (par && $changed(ddrDataPair) |->
         $changed(forwardedOutputClock))
      else $error("data moved off a clock edge");
   par_lat_a:
      assert property (par && !sck && !sleepMode && $rose(encodeClock)
         |-> ##[2:6] $fell(forwardedOutputClock))
      else $error("no low phase after encode rise");
   cover property (par && $rose(sleepMode));
   cover property ($rose(sdoOe));
   cover property (par && overrangeFlag);
endmodule : adc_ddr_output_sva
`default_nettype wire

// file: verif/spi_host_model.sv
// Serial host model on the configuration pins
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // Clock
   input  wire logic mclk,
   // Serial pins
   output var logic  csN,
   output var logic  sck,
   output var logic  sdi,
   input  wire logic sdoOe
);
   ////////////////////
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      sdi = 1'b0;
   end
   // Half periods of 4 clocks, since the pins are oversampled
   task automatic xfer(input logic [15:0] f, input int nb,
                       output logic [7:0] rd);
      rd = 8'h00;
      csN = 1'b0;
      for (int i = 15; i > 15 - nb; i--) begin
         sdi = f[i];
         repeat (4) @(negedge mclk);
         sck = 1'b1;
         repeat (4) @(negedge mclk);
         if (i < 8) rd[i] = ~sdoOe;
         sck = 1'b0;
      end
      repeat (4) @(negedge mclk);
      csN = 1'b1;
      sdi = ~sdi;
      repeat (4) @(negedge mclk);
   endtask : xfer
   task automatic pins(input logic c, input logic s, input logic d);
      csN = c;
      sck = s;
      sdi = d;
   endtask : pins
endmodule : spi_host_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench for the converter output and config port
`timescale 1ns/1ps
`default_nettype none
module tb
   import adc_ddr_pkg::*;
;
   logic        mclk, rst, encodeClock, overRangeIn, programmingModeStrap;
   logic        csN, sck, sdi, sdoOut, sdoOe, overrangeFlag, sleepMode;
   logic        forwardedOutputClock, dutyStabilizerOn, lowDriveCurrent;
   logic        twosComplement;
   logic [11:0] sampleIn;
   logic [5:0]  ddrDataPair;
   logic [4:0]  outs;
   logic [12:0] hist [0:1023];
   logic [7:0]  rd;
   int          rc, errorCnt, compares;
   ////////////////////
   adc_ddr_output i_dut (.mclk, .rst, .clkEn(1'b1), .encodeClock,
      .sampleIn, .overRangeIn, .programmingModeStrap, .csN, .sck, .sdi,
      .sdoOut, .sdoOe, .ddrDataPair, .overrangeFlag, .forwardedOutputClock,
      .sleepMode, .dutyStabilizerOn, .lowDriveCurrent, .twosComplement);
   spi_host_model i_host (.mclk, .csN, .sck, .sdi, .sdoOe);
   assign outs = {sdoOe, twosComplement, sleepMode, dutyStabilizerOn,
                  lowDriveCurrent};
   initial mclk = 1'b0;
   always #50 mclk = ~mclk;
   // Odd offset keeps encode edges away from system clock edges
   initial begin
      encodeClock = 1'b0;
      #37;
      forever #400 encodeClock = ~encodeClock;
   end
   always @(posedge encodeClock) begin
      hist[rc % 1024] <= {overRangeIn, sampleIn};
      rc <= rc + 1;
   end
   always @(negedge encodeClock) begin
      @(negedge mclk);
      sampleIn <= 12'(rc * 677 + 961);
      overRangeIn <= rc % 3 == 0;
   end
   ////////////////////
   task automatic cmp(input string nm, input logic [11:0] e, g);
      compares++;
      if (g !== e) begin
         errorCnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp
   task automatic wrap_up;
      $display("compares %0d errorCnt %0d", compares, errorCnt);
      if (errorCnt == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : wrap_up
   task automatic rstSeq(input logic par);
      rst = 1'b1;
      programmingModeStrap = par;
      repeat (5) @(negedge mclk);
      rst = 1'b0;
      repeat (8) @(posedge encodeClock);
      @(negedge mclk);
   endtask : rstSeq
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_host.xfer({1'b0, a, d}, 16, rd);
   endtask : wr
   // Word of rise k must show six rises later
   task automatic stream(input int n, input logic inv);
      int          k;
      logic [12:0] e;
      logic [5:0]  ev, od;
      repeat (n) begin
         @(posedge encodeClock);
         k = rc;
         e = hist[(k + 1018) % 1024];
         for (int i = 0; i < 6; i++) begin
            ev[i] = e[2 * i];
            od[i] = e[2 * i + 1];
         end
         #600;
         cmp("evenBits", 12'(ev), 12'(ddrDataPair));
         cmp("flagLow", 12'(e[12]), 12'(overrangeFlag));
         cmp("clkLow", 12'(inv), 12'(forwardedOutputClock));
         // High phase stands only until the next rise is detected
         #100;
         cmp("oddBits", 12'(od), 12'(ddrDataPair));
         cmp("flagHigh", 12'h0, 12'(overrangeFlag));
         cmp("clkHigh", 12'(!inv), 12'(forwardedOutputClock));
      end
      @(negedge mclk);
   endtask : stream
   // Counts to the edge into lvl, not a level left from the last cycle
   task automatic lag(input logic lvl, output int c);
      logic seen;
      @(posedge encodeClock);
      c = 0;
      seen = 1'b0;
      while (!(seen && forwardedOutputClock === lvl) && c < 20) begin
         if (forwardedOutputClock !== lvl) seen = 1'b1;
         @(negedge mclk);
         c++;
      end
      if (c == 20) begin
         errorCnt++;
         wrap_up();
      end
      @(negedge mclk);
   endtask : lag
   task automatic tPhase;
      int la, lb;
      wr(ADDR_TIMING, 8'h01);
      cmp("stabilizer", 12'h1, 12'(dutyStabilizerOn));
      lag(1'b0, la);
      wr(ADDR_TIMING, 8'h07);
      lag(1'b0, lb);
      cmp("phaseLag", 12'(la + 3), 12'(lb));
      wr(ADDR_TIMING, 8'h09);
      stream(3, 1'b1);
   endtask : tPhase
   task automatic tRegs;
      wr(ADDR_TIMING, 8'h00);
      i_host.xfer({1'b0, ADDR_TIMING, 8'hff}, 12, rd);
      cmp("abort", 12'h0, 12'(outs));
      wr(ADDR_OUTPUT, 8'h01);
      wr(ADDR_FORMAT, 8'h01);
      wr(ADDR_POWER, 8'h01);
      cmp("written", 12'hd, 12'(outs));
      // Timing and the unmapped fifth address read as zero
      for (int a = 1; a < 6; a++) begin
         i_host.xfer({1'b1, 7'(a), 8'h00}, 16, rd);
         cmp("readBack", 12'(a % 3 != 2), 12'(rd));
      end
      wr(ADDR_RESET, 8'h80);
      cmp("regReset", 12'h0, 12'(outs));
   endtask : tRegs
   task automatic tParallel;
      rstSeq(1'b1);
      i_host.pins(1'b1, 1'b0, 1'b1);
      repeat (8) @(negedge mclk);
      cmp("parPins", 12'h3, 12'(outs));
      stream(8, 1'b0);
      i_host.pins(1'b0, 1'b1, 1'b0);
      repeat (8) @(negedge mclk);
      cmp("parSleep", 12'h4, 12'(outs));
      i_host.pins(1'b0, 1'b0, 1'b0);
      repeat (8) @(negedge mclk);
      cmp("parWake", 12'h0, 12'(outs));
   endtask : tParallel
   ////////////////////
   initial begin
      sampleIn = 12'h000;
      overRangeIn = 1'b0;
      rstSeq(1'b0);
      cmp("resetOuts", 12'h0, 12'(outs));
      stream(10, 1'b0);
      tPhase();
      tRegs();
      tParallel();
      wrap_up();
   end
endmodule : tb
bind adc_ddr_output adc_ddr_output_sva #(.PAIRS(PAIRS)) i_sva (.mclk,
   .rst, .encodeClock, .programmingModeStrap, .csN, .sck, .sdi, .sdoOut,
   .sdoOe, .ddrDataPair, .overrangeFlag, .forwardedOutputClock, .sleepMode,
   .dutyStabilizerOn, .lowDriveCurrent);
`default_nettype wire
